//--- modem_ctrl_defs.svh
// register map, field positions, reset values and timing counts of the modem control logic
// How it works
// - with clock select low, the default, the input clock divided by 16 goes unchanged to the baud divider unit.
// - with clock select high, that divided clock is divided by four more before the baud divider unit.
// - with infrared enable low, the default, the serial pins carry the plain modem receive and transmit data.
// - with infrared enable high, transmit and receive pass through the infrared encoder and decoder.
// - in infrared mode the transmit pin stays low while no data is being sent.
// - with interrupt type low, the default, the interrupt pin is driven active or left three-state.
// - with interrupt type high, the interrupt pin is an open-source wire-OR driver for a shared line.
// - loop-back, reset low, cuts transmit and the receive and modem inputs off the pins and loops them inside.
// - in loop-back the receive and transmit interrupts keep working as in normal operation.
// - in loop-back the modem status events come from the lower four modem control bits, not the pins.
// - in loop-back every interrupt source is still gated by the interrupt enable register.
// - in loop-back the aux output two bit is the source of the internal carrier detect.
// - with interrupt type low, aux output two low makes the pin three-state and internal carrier low; high makes it active and carrier high.
`ifndef MODEM_CTRL_DEFS_SVH
`define MODEM_CTRL_DEFS_SVH
// ======================================================
// register offsets
`define REG_MODEM_CONTROL 8'h00
`define REG_INT_ENABLE 8'h04
`define REG_INT_STATUS 8'h08
`define REG_MODEM_STATUS 8'h0C
// ======================================================
// modem control fields
`define MC_DTR_BIT 0
`define MC_RTS_BIT 1
`define MC_AUX_ONE_BIT 2
`define MC_AUX_TWO_BIT 3
`define MC_LOOP_BIT 4
`define MC_INT_TYPE_BIT 5
`define MC_IR_EN_BIT 6
`define MC_CLK_SEL_BIT 7
`define MODEM_CONTROL_RESET 8'h00
`define INT_ENABLE_RESET 4'h0
// ======================================================
// interrupt status fields
`define INT_RX_BIT 0
`define INT_TX_BIT 1
`define INT_LINE_BIT 2
`define INT_MODEM_BIT 3
// ======================================================
// timing counts
`define PRESCALE_DIV 16
`define CLOCK_SEL_DIV 4
`define IR_BIT_TICKS 16
`define IR_PULSE_TICKS 3
`endif

//--- modem_ctrl_pkg.sv
// types shared by the modem control logic
package modem_ctrl_pkg;
  typedef enum logic [0:0] {
    IR_RX_IDLE = 1'b0,
    IR_RX_HOLD = 1'b1
  } ir_rx_state_e;
endpackage : modem_ctrl_pkg

//--- pin_sync.sv
// three-stage synchroniser for pin inputs, one per bit
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 5,
  parameter logic [WIDTH-1:0] RESET_VALUE = '1
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_level;
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      // stage1 feeds only stage2; a change counts once stages two and three agree
      always_comb begin
        next_level[i] = (stage2[i] == stage3[i]) ? stage3[i] : level[i];
      end
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          stage1[i] <= RESET_VALUE[i];
          stage2[i] <= RESET_VALUE[i];
          stage3[i] <= RESET_VALUE[i];
          level[i] <= RESET_VALUE[i];
        end else begin
          stage1[i] <= pin_in[i];
          stage2[i] <= stage1[i];
          stage3[i] <= stage2[i];
          level[i] <= next_level[i];
        end
      end
    end
  endgenerate
endmodule : pin_sync

//--- baud_prescaler.sv
// input clock prescaler ahead of the baud divider unit
`timescale 1ns/1ps
`include "modem_ctrl_defs.svh"
module baud_prescaler (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic div4_sel,
  output logic clock_tick
);
  localparam logic [5:0] LIMIT_1 = 6'(`PRESCALE_DIV - 1);
  localparam logic [5:0] LIMIT_4 = 6'(`PRESCALE_DIV * `CLOCK_SEL_DIV - 1);
  logic [5:0] count;
  logic [5:0] next_count;
  logic [5:0] limit;
  logic next_tick;
  always_comb begin
    limit = div4_sel ? LIMIT_4 : LIMIT_1;
    // >= so a switch from 64 down to 16 mid-count cannot overrun
    next_tick = (count >= limit);
    next_count = next_tick ? 6'h00 : count + 6'h01;
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      count <= 6'h00;
      clock_tick <= 1'b0;
    end else begin
      count <= next_count;
      clock_tick <= next_tick;
    end
  end
endmodule : baud_prescaler

//--- modem_control_register_logic.sv
// modem control register, serial routing, loop-back and interrupt pin control
`timescale 1ns/1ps
`include "modem_ctrl_defs.svh"
module modem_control_register_logic (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tx_serial,
  output logic rx_serial,
  input wire logic baud_x16_tick,
  output logic baud_clock_tick,
  input wire logic rx_int_req,
  input wire logic tx_int_req,
  input wire logic line_int_req,
  output logic tx_pin,
  input wire logic rx_pin,
  input wire logic cts_pin_n,
  input wire logic dsr_pin_n,
  input wire logic dcd_pin_n,
  input wire logic ri_pin_n,
  output logic interrupt_request_pin_out,
  output logic interrupt_request_pin_oe
);
  // ======================================================
  // registers and bus
  logic [7:0] modem_control;
  logic [3:0] interrupt_enable_register;
  logic [3:0] int_status;
  logic [3:0] modem_delta;
  logic [7:0] next_modem_control;
  logic [3:0] next_int_enable;
  logic [3:0] next_int_status;
  logic [3:0] next_modem_delta;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic setup;
  logic wr_done;
  logic rd_done;
  logic mapped;
  logic loop_on;
  logic ir_on;
  logic aux_output_two;
  logic [4:0] pin_level;
  logic [3:0] modem_n;
  logic [3:0] modem_prev_n;
  logic [3:0] modem_event;
  logic [2:0] req_prev;
  logic [3:0] int_event;
  logic irq;

  assign loop_on = modem_control[`MC_LOOP_BIT];
  assign ir_on = modem_control[`MC_IR_EN_BIT];
  assign aux_output_two = modem_control[`MC_AUX_TWO_BIT];
  assign setup = psel & ~penable;
  assign wr_done = psel & penable & pwrite;
  assign rd_done = psel & penable & ~pwrite;
  // zero wait states: every access phase completes at once
  assign pready = psel & penable;
  assign mapped = (paddr == `REG_MODEM_CONTROL) || (paddr == `REG_INT_ENABLE) ||
                  (paddr == `REG_INT_STATUS) || (paddr == `REG_MODEM_STATUS);

  baud_prescaler u_prescaler (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .div4_sel(modem_control[`MC_CLK_SEL_BIT]),
    .clock_tick(baud_clock_tick)
  );

  pin_sync #(.WIDTH(5), .RESET_VALUE(5'h1F)) u_pin_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pin_in({rx_pin, dcd_pin_n, ri_pin_n, dsr_pin_n, cts_pin_n}),
    .level(pin_level)
  );

  // ======================================================
  // modem inputs, active low: {dcd, ri, dsr, cts}
  always_comb begin
    if (loop_on) begin
      // pins ignored; outputs fed straight back
      modem_n[0] = ~modem_control[`MC_RTS_BIT];
      modem_n[1] = ~modem_control[`MC_DTR_BIT];
      modem_n[2] = ~modem_control[`MC_AUX_ONE_BIT];
      modem_n[3] = ~aux_output_two;
    end else begin
      modem_n = pin_level[3:0];
    end
    // cts, dsr, dcd on any change; ri on its trailing edge
    modem_event[0] = modem_n[0] ^ modem_prev_n[0];
    modem_event[1] = modem_n[1] ^ modem_prev_n[1];
    modem_event[2] = modem_n[2] & ~modem_prev_n[2];
    modem_event[3] = modem_n[3] ^ modem_prev_n[3];
    // receive and transmit requests run the same in loop-back
    int_event[`INT_RX_BIT] = rx_int_req & ~req_prev[0];
    int_event[`INT_TX_BIT] = tx_int_req & ~req_prev[1];
    int_event[`INT_LINE_BIT] = line_int_req & ~req_prev[2];
    int_event[`INT_MODEM_BIT] = |modem_event;
  end

  // ======================================================
  // register file
  always_comb begin
    next_modem_control = modem_control;
    next_int_enable = interrupt_enable_register;
    next_prdata = prdata;
    next_pslverr = pslverr;
    next_int_status = int_status;
    next_modem_delta = modem_delta;
    if (wr_done && paddr == `REG_MODEM_CONTROL) begin
      next_modem_control = pwdata[7:0];
    end
    if (wr_done && paddr == `REG_INT_ENABLE) begin
      next_int_enable = pwdata[3:0];
    end
    // clear only what the read returned, so nothing arriving later is lost
    if (rd_done && paddr == `REG_INT_STATUS) begin
      next_int_status = int_status & ~prdata[3:0];
    end
    if (rd_done && paddr == `REG_MODEM_STATUS) begin
      next_modem_delta = modem_delta & ~prdata[3:0];
    end
    // set wins over clear
    next_int_status = next_int_status | int_event;
    next_modem_delta = next_modem_delta | modem_event;
    if (setup) begin
      next_pslverr = ~mapped;
      case (paddr)
        `REG_MODEM_CONTROL: next_prdata = {24'h000000, modem_control};
        `REG_INT_ENABLE: next_prdata = {28'h0000000, interrupt_enable_register};
        `REG_INT_STATUS: next_prdata = {28'h0000000, int_status};
        `REG_MODEM_STATUS: next_prdata = {24'h000000, ~modem_n, modem_delta};
        default: next_prdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      modem_control <= `MODEM_CONTROL_RESET;
      interrupt_enable_register <= `INT_ENABLE_RESET;
      int_status <= 4'h0;
      modem_delta <= 4'h0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
      modem_prev_n <= 4'hF;
      req_prev <= 3'h0;
    end else begin
      modem_control <= next_modem_control;
      interrupt_enable_register <= next_int_enable;
      int_status <= next_int_status;
      modem_delta <= next_modem_delta;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
      modem_prev_n <= modem_n;
      req_prev <= {line_int_req, tx_int_req, rx_int_req};
    end
  end

  // ======================================================
  // interrupt pin
  logic next_int_out;
  logic next_int_oe;
  always_comb begin
    irq = |(int_status & interrupt_enable_register);
    if (modem_control[`MC_INT_TYPE_BIT]) begin
      // wire-OR: drive high only while asserting, pull-down does the rest
      next_int_out = 1'b1;
      next_int_oe = irq;
    end else begin
      next_int_out = irq;
      next_int_oe = aux_output_two;
    end
  end

  // ======================================================
  // serial routing and infrared coding
  modem_ctrl_pkg::ir_rx_state_e ir_state;
  modem_ctrl_pkg::ir_rx_state_e next_ir_state;
  logic [3:0] ir_rx_count;
  logic [3:0] next_ir_rx_count;
  logic [3:0] ir_tx_phase;
  logic [3:0] next_ir_tx_phase;
  logic tx_prev;
  logic next_tx_pin;
  logic next_rx_serial;
  logic ir_rx_bit;
  always_comb begin
    next_ir_state = ir_state;
    next_ir_rx_count = ir_rx_count;
    next_ir_tx_phase = ir_tx_phase;
    // encoder phase restarts on every data edge to align pulses to bits
    if (tx_serial != tx_prev) begin
      next_ir_tx_phase = 4'h0;
    end else if (baud_x16_tick) begin
      next_ir_tx_phase = ir_tx_phase + 4'h1;
    end
    case (ir_state)
      modem_ctrl_pkg::IR_RX_IDLE: begin
        if (pin_level[4]) begin
          next_ir_state = modem_ctrl_pkg::IR_RX_HOLD;
          next_ir_rx_count = 4'h0;
        end
      end
      modem_ctrl_pkg::IR_RX_HOLD: begin
        if (baud_x16_tick) begin
          next_ir_rx_count = ir_rx_count + 4'h1;
          if (ir_rx_count == 4'(`IR_BIT_TICKS - 1)) begin
            next_ir_state = modem_ctrl_pkg::IR_RX_IDLE;
          end
        end
      end
      default: next_ir_state = modem_ctrl_pkg::IR_RX_IDLE;
    endcase
    // a light pulse stands for a zero bit for one bit time
    ir_rx_bit = ~((ir_state == modem_ctrl_pkg::IR_RX_HOLD) | pin_level[4]);
    if (loop_on) begin
      next_tx_pin = ~ir_on;
      next_rx_serial = tx_serial;
    end else if (ir_on) begin
      next_tx_pin = ~tx_serial & (ir_tx_phase < 4'(`IR_PULSE_TICKS));
      next_rx_serial = ir_rx_bit;
    end else begin
      next_tx_pin = tx_serial;
      next_rx_serial = pin_level[4];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ir_state <= modem_ctrl_pkg::IR_RX_IDLE;
      ir_rx_count <= 4'h0;
      ir_tx_phase <= 4'h0;
      tx_prev <= 1'b1;
      tx_pin <= 1'b1;
      rx_serial <= 1'b1;
      interrupt_request_pin_out <= 1'b0;
      interrupt_request_pin_oe <= 1'b0;
    end else begin
      ir_state <= next_ir_state;
      ir_rx_count <= next_ir_rx_count;
      ir_tx_phase <= next_ir_tx_phase;
      tx_prev <= tx_serial;
      tx_pin <= next_tx_pin;
      rx_serial <= next_rx_serial;
      interrupt_request_pin_out <= next_int_out;
      interrupt_request_pin_oe <= next_int_oe;
    end
  end

  // ======================================================
  // checks
  logic [6:0] tick_gap;
  logic gap_valid;
  logic sel_prev;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tick_gap <= 7'h00;
      gap_valid <= 1'b0;
      sel_prev <= 1'b0;
    end else begin
      sel_prev <= modem_control[`MC_CLK_SEL_BIT];
      tick_gap <= baud_clock_tick ? 7'h01 : tick_gap + 7'h01;
      if (baud_clock_tick) begin
        gap_valid <= 1'b1;
      end else if (sel_prev != modem_control[`MC_CLK_SEL_BIT]) begin
        gap_valid <= 1'b0;
      end
    end
  end

  sequence loop_steady_s;
    loop_on && $stable(modem_control);
  endsequence

  div16_gap_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    baud_clock_tick && gap_valid && !sel_prev |-> tick_gap == 7'd16)
    else $error("prescaler period is not 16 with clock select low");
  div64_gap_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    baud_clock_tick && gap_valid && sel_prev |-> tick_gap == 7'd64)
    else $error("prescaler period is not 64 with clock select high");
  plain_tx_route_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !ir_on && !loop_on |=> tx_pin == $past(tx_serial))
    else $error("transmit pin does not follow data in plain mode");
  ir_idle_low_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ir_on && !loop_on && tx_serial ##1 ir_on && !loop_on && tx_serial |=> !tx_pin)
    else $error("infrared transmit pin not low while idle");
  ir_rx_pulse_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ir_on && !loop_on && $rose(pin_level[4]) |=> !rx_serial)
    else $error("infrared pulse did not give a zero bit");
  active_pin_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !modem_control[`MC_INT_TYPE_BIT] |=> interrupt_request_pin_oe == $past(aux_output_two)
      && interrupt_request_pin_out == $past(irq))
    else $error("active interrupt pin mode wrong");
  open_source_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    modem_control[`MC_INT_TYPE_BIT] |=> interrupt_request_pin_oe == $past(irq)
      && interrupt_request_pin_out)
    else $error("open-source interrupt pin drives when idle");
  loop_serial_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    loop_on |=> rx_serial == $past(tx_serial) && tx_pin == !$past(ir_on))
    else $error("loop-back serial path wrong");
  loop_dcd_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    loop_steady_s ##1 loop_steady_s |-> modem_prev_n[3] == !aux_output_two)
    else $error("loop-back carrier detect does not follow aux output two");
  rx_irq_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(rx_int_req) && interrupt_enable_register[`INT_RX_BIT] |=> irq ##1 interrupt_request_pin_out)
    else $error("enabled receive event gave no interrupt");
endmodule : modem_control_register_logic

//--- serial_far_end.sv
// far-side model of a modem or infrared transceiver on the serial pins
`timescale 1ns/1ps
module serial_far_end (
  input wire logic clk_sys,
  input wire logic tx_pin,
  input wire logic line_level,
  input wire logic [3:0] modem_level_n,
  output logic rx_pin,
  output logic cts_pin_n,
  output logic dsr_pin_n,
  output logic dcd_pin_n,
  output logic ri_pin_n,
  output logic heard_tx
);
  // ======================================================
  // pin drive
  // levels move only after a clk_sys edge, one cycle behind, on the same clock that runs the logic under test
  initial begin
    rx_pin = 1'b1;
    {ri_pin_n, dcd_pin_n, dsr_pin_n, cts_pin_n} = 4'hF;
    heard_tx = 1'b1;
  end
  always @(posedge clk_sys) begin
    rx_pin <= line_level;
    {ri_pin_n, dcd_pin_n, dsr_pin_n, cts_pin_n} <= modem_level_n;
    heard_tx <= tx_pin;
  end
endmodule : serial_far_end

//--- tb.sv
// self-checking testbench of the modem control register logic
`timescale 1ns/1ps
`include "modem_ctrl_defs.svh"
module tb;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, rx_serial, baud_clock_tick, tx_pin, rx_pin, irq_out, irq_oe, heard_tx;
  logic cts_pin_n, dsr_pin_n, dcd_pin_n, ri_pin_n;
  logic tx_serial = 1'b1;
  logic baud_x16_tick = 1'b0;
  logic [2:0] reqs = 3'h0;
  logic line_level = 1'b1;
  logic [3:0] modem_level_n = 4'hF;
  logic [1:0] tick_div = 2'h0;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;
  modem_control_register_logic dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_serial(tx_serial), .rx_serial(rx_serial), .baud_x16_tick(baud_x16_tick),
    .baud_clock_tick(baud_clock_tick), .rx_int_req(reqs[0]), .tx_int_req(reqs[1]), .line_int_req(reqs[2]),
    .tx_pin(tx_pin), .rx_pin(rx_pin), .cts_pin_n(cts_pin_n), .dsr_pin_n(dsr_pin_n), .dcd_pin_n(dcd_pin_n),
    .ri_pin_n(ri_pin_n), .interrupt_request_pin_out(irq_out), .interrupt_request_pin_oe(irq_oe));
  serial_far_end far (.clk_sys(clk_sys), .tx_pin(tx_pin), .line_level(line_level),
    .modem_level_n(modem_level_n), .rx_pin(rx_pin), .cts_pin_n(cts_pin_n), .dsr_pin_n(dsr_pin_n),
    .dcd_pin_n(dcd_pin_n), .ri_pin_n(ri_pin_n), .heard_tx(heard_tx));
  // ======================================================
  // clock, 16x tick and watchdog
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    tick_div <= tick_div + 2'h1;
    baud_x16_tick <= (tick_div == 2'h3);
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      results();
    end
  end
  // ======================================================
  // helpers
  task results;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk
  task wait_c(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : wait_c
  // one apb transfer; read data and error taken at the pready edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic err);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // no cycle count assumed: only the watchdog ends a wait that never completes
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask, input string msg);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q & mask, exp, msg);
    chk(e, 1'b0, "read error flag");
  endtask : rd
  // ======================================================
  // scenarios
  task t_reset;
    logic [31:0] q;
    logic e;
    chk({tx_pin, irq_out, irq_oe}, 3'h4, "reset pins");
    rd(`REG_MODEM_CONTROL, `MODEM_CONTROL_RESET, 32'hFFFFFFFF, "mc reset");
    rd(`REG_INT_ENABLE, 32'h0, 32'hFFFFFFFF, "enable reset");
    apb(1'b0, 8'h10, 32'h0, q, e);
    chk({e, q}, {1'b1, 32'h0}, "unmapped");
  endtask : t_reset
  task t_baud(input logic sel, input int exp);
    int n;
    wr(`REG_MODEM_CONTROL, {24'h0, sel, 7'h0});
    n = 0;
    while (baud_clock_tick !== 1'b1 && n < 200) begin
      @(posedge clk_sys);
      n++;
    end
    wait_c(1);
    n = 1;
    while (baud_clock_tick !== 1'b1 && n < 200) begin
      @(posedge clk_sys);
      n++;
    end
    chk(n, exp, "tick spacing");
  endtask : t_baud
  task t_data;
    wr(`REG_MODEM_CONTROL, 32'h00);
    tx_serial <= 1'b0;
    line_level <= 1'b0;
    wait_c(8);
    chk({heard_tx, rx_serial}, 2'b00, "plain path");
    wr(`REG_MODEM_CONTROL, 32'h10);
    wait_c(8);
    chk({tx_pin, rx_serial}, 2'b10, "loop tx0");
    tx_serial <= 1'b1;
    wait_c(8);
    chk({tx_pin, rx_serial}, 2'b11, "loop tx1");
    wr(`REG_MODEM_CONTROL, 32'h50);
    wait_c(4);
    chk({tx_pin, rx_serial}, 2'b01, "loop ir idle");
    line_level <= 1'b1;
  endtask : t_data
  task t_ir;
    int hi;
    wr(`REG_MODEM_CONTROL, 32'h40);
    wait_c(8);
    hi = 0;
    repeat (40) begin
      @(posedge clk_sys);
      hi += tx_pin;
    end
    chk(hi, 0, "ir idle low");
    tx_serial <= 1'b0;
    hi = 0;
    repeat (60) begin
      @(posedge clk_sys);
      hi += tx_pin;
    end
    // pulse width tolerates one tick of phase slip at the start
    chk(hi >= 8 && hi <= 16, 1'b1, "ir pulse");
    tx_serial <= 1'b1;
    wait_c(70);
    // receive side: dark line is idle, a short light pulse is a zero bit
    line_level <= 1'b0;
    wait_c(90);
    chk(rx_serial, 1'b1, "ir rx idle");
    line_level <= 1'b1;
    wait_c(4);
    line_level <= 1'b0;
    wait_c(8);
    chk(rx_serial, 1'b0, "ir rx pulse");
    wait_c(80);
    chk(rx_serial, 1'b1, "ir rx bit end");
    line_level <= 1'b1;
  endtask : t_ir
  task t_irq;
    wr(`REG_MODEM_CONTROL, 32'h08);
    for (int i = 0; i < 3; i++) begin
      wr(`REG_INT_ENABLE, 32'h1 << i);
      reqs[i] <= 1'b1;
      wait_c(4);
      chk({irq_out, irq_oe}, 2'b11, "irq active");
      rd(`REG_INT_STATUS, 32'h1 << i, 32'hF, "status");
      reqs[i] <= 1'b0;
      wait_c(4);
      chk(irq_out, 1'b0, "irq cleared");
    end
    wr(`REG_INT_ENABLE, 32'h0);
    reqs[0] <= 1'b1;
    wait_c(4);
    chk(irq_out, 1'b0, "masked");
    rd(`REG_INT_STATUS, 32'h1, 32'hF, "masked status");
    reqs[0] <= 1'b0;
    wr(`REG_MODEM_CONTROL, 32'h30);
    rd(`REG_MODEM_STATUS, 32'h0, 32'hFFFFFFFF, "loop modem idle");
    wr(`REG_INT_ENABLE, 32'h2);
    reqs[1] <= 1'b1;
    wait_c(4);
    chk({irq_out, irq_oe}, 2'b11, "open source on");
    rd(`REG_INT_STATUS, 32'h2, 32'h2, "tx status");
    reqs[1] <= 1'b0;
    wait_c(4);
    chk(irq_oe, 1'b0, "open source off");
  endtask : t_irq
  task t_modem;
    modem_level_n <= 4'h0;
    wr(`REG_INT_ENABLE, 32'h8);
    wr(`REG_MODEM_CONTROL, 32'h1A);
    wait_c(6);
    rd(`REG_MODEM_STATUS, 32'h99, 32'hFFFFFFFF, "loop modem");
    chk({irq_out, irq_oe}, 2'b11, "modem irq");
    rd(`REG_INT_STATUS, 32'h8, 32'h8, "modem status bit");
    wr(`REG_MODEM_CONTROL, 32'h12);
    wait_c(6);
    rd(`REG_MODEM_STATUS, 32'h18, 32'hFFFFFFFF, "carrier off");
    wr(`REG_INT_ENABLE, 32'h0);
  endtask : t_modem
  // ======================================================
  // main sequence
  initial begin
    wait_c(20);
    rst_n <= 1'b1;
    t_reset();
    t_baud(1'b0, `PRESCALE_DIV);
    t_baud(1'b1, `PRESCALE_DIV * `CLOCK_SEL_DIV);
    t_data();
    t_ir();
    t_irq();
    t_modem();
    results();
  end
endmodule : tb
